/* File: vsc_pkg.sv */
// Package for the voice store serial command unit: frame layout, opcodes, timing.
// Assumes a 100 MHz system clock; the serial link runs on the master's clock.
package vsc_pkg;

  // ==========================================================================
  // Frame layout
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned CTRL_W     = 5;
  localparam int unsigned FRAME_W    = ADDR_W + CTRL_W;
  localparam int unsigned STATUS_W   = ADDR_W + 2;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  FRAME_BITS = 5'h10;

  // Control field bit positions, in the order the bits arrive.
  localparam int unsigned C_SKIP  = 0;
  localparam int unsigned C_IGN   = 1;
  localparam int unsigned C_PWR   = 2;
  localparam int unsigned C_DIR   = 3;
  localparam int unsigned C_RUN   = 4;

  // Status word positions.
  localparam int unsigned S_OVF   = 0;
  localparam int unsigned S_EOM   = 1;
  localparam int unsigned S_PTR   = 2;

  // ==========================================================================
  // Storage geometry
  localparam logic [10:0] ROW_COUNT = 11'h04b0;
  localparam logic [10:0] ROW_LAST  = 11'h04af;
  localparam int unsigned ROW_CELLS = 1600;
  localparam logic [10:0] ROW_ZERO  = 11'h0000;
  localparam logic [10:0] ROW_ONE   = 11'h0001;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned WAKE_DELAY_MS  = 25;
  localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned ROW_TIME_US    = 200;
  localparam int unsigned ROW_TIME_CYC   = ROW_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Decoded instructions
  typedef enum logic [3:0] {
    VSC_CMD_NONE,
    VSC_CMD_WAKE,
    VSC_CMD_LISTEN_AT,
    VSC_CMD_LISTEN,
    VSC_CMD_CAPTURE_AT,
    VSC_CMD_CAPTURE,
    VSC_CMD_SKIP_AT,
    VSC_CMD_SKIP,
    VSC_CMD_HALT,
    VSC_CMD_SLEEP
  } vsc_cmd_t;

  typedef enum logic [1:0] {
    VSC_OP_IDLE,
    VSC_OP_LISTEN,
    VSC_OP_CAPTURE,
    VSC_OP_SKIP
  } vsc_op_t;

  // Maps the 5 control bits to an instruction; unknown patterns give NONE.
  function automatic vsc_cmd_t vsc_decode(input logic [4:0] c);
    vsc_cmd_t r;
    r = VSC_CMD_NONE;
    if (!c[C_RUN] && !c[C_PWR] && c[C_IGN])
      r = VSC_CMD_SLEEP;
    else if (!c[C_RUN] && c[C_PWR] && c[C_IGN] && !c[C_SKIP])
      r = VSC_CMD_HALT;
    else if (c == 5'h04)
      r = VSC_CMD_WAKE;
    else if (c == 5'h1c)
      r = VSC_CMD_LISTEN_AT;
    else if (c == 5'h1e)
      r = VSC_CMD_LISTEN;
    else if (c == 5'h14)
      r = VSC_CMD_CAPTURE_AT;
    else if (c == 5'h16)
      r = VSC_CMD_CAPTURE;
    else if (c == 5'h1d)
      r = VSC_CMD_SKIP_AT;
    else if (c == 5'h1f)
      r = VSC_CMD_SKIP;
    return r;
  endfunction : vsc_decode

endpackage : vsc_pkg

/* File: vsc_sync.sv */
// Two-flop synchroniser for a level into the system clock domain.
// Assumes the input is a slow level or a toggle held for several cycles.
`timescale 1ns/1ps
module vsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Level
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : vsc_sync

/* File: vsc_link.sv */
// Serial shift engine on the master's clock: captures a 16-bit frame, shifts status out.
// Assumes the link clock idles outside frames; frame start and end come from slave select.
`timescale 1ns/1ps
module vsc_link (
  // Link clock and frame select
  input  wire logic                          sclk,
  input  wire logic                          ss_n,
  // Serial data
  input  wire logic                          mosi,
  output logic                               miso,
  output logic                               miso_oe,
  // Status word to send, held stable by the core during a frame
  input  wire logic [vsc_pkg::STATUS_W-1:0] status_in,
  // Received frame, valid when frame_toggle flips
  output logic [vsc_pkg::FRAME_W-1:0]        frame_out,
  output logic                               frame_toggle
);

  logic [vsc_pkg::FRAME_W-1:0]  rx_q;
  logic [vsc_pkg::FRAME_W-1:0]  rx_d;
  logic [vsc_pkg::CNT_W-1:0]    cnt_q;
  logic [vsc_pkg::CNT_W-1:0]    cnt_d;
  logic [vsc_pkg::STATUS_W-1:0] shadow_q;
  logic [vsc_pkg::STATUS_W-1:0] shadow_d;
  logic                         first_q;
  logic                         first_d;
  // The link has no reset pin, so the toggle starts from a known level.
  logic                         tog_q = 1'b0;
  logic                         tog_d;
  logic [vsc_pkg::FRAME_W-1:0]  hold_q;
  logic [vsc_pkg::FRAME_W-1:0]  hold_d;

  // ==========================================================================
  // Receive: MOSI sampled on rising edge, LSB first. The slave select high
  // level clears the bit count asynchronously so a new frame always
  // starts at bit zero even though the link clock stands still between frames.
  always_comb begin
    rx_d  = {mosi, rx_q[vsc_pkg::FRAME_W-1:1]}; // RULE_03
    cnt_d = (cnt_q == vsc_pkg::FRAME_BITS) ? cnt_q : cnt_q + 5'h01;
  end

  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      cnt_q <= 5'h00; // RULE_01
      rx_q  <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
      rx_q  <= rx_d;
    end
  end

  // ==========================================================================
  // Frame hand-over on the rising edge of slave select: it is the last event of
  // a frame, so the toggle flips there and only frames of at least 16 bits pass.
  always_comb begin
    hold_d = rx_q;
    tog_d  = (cnt_q == vsc_pkg::FRAME_BITS) ? ~tog_q : tog_q; // RULE_04
  end

  always_ff @(posedge ss_n) begin
    hold_q <= hold_d; // RULE_09
    tog_q  <= tog_d;
  end

  // ==========================================================================
  // Transmit: the first bit drives straight from the status word until the
  // first falling edge, which loads the rest; later falls shift it down.
  always_comb begin
    first_d  = 1'b0;
    shadow_d = first_q ? {1'b0, status_in[vsc_pkg::STATUS_W-1:1]} :
                         {1'b0, shadow_q[vsc_pkg::STATUS_W-1:1]}; // RULE_07
  end

  always_ff @(negedge sclk or posedge ss_n) begin
    if (ss_n) begin
      first_q  <= 1'b1;
      shadow_q <= 13'h0000;
    end else begin
      first_q  <= first_d;
      shadow_q <= shadow_d; // RULE_03
    end
  end

  assign miso         = first_q ? status_in[0] : shadow_q[0]; // RULE_19
  assign miso_oe      = ~ss_n;
  assign frame_out    = hold_q;
  assign frame_toggle = tog_q;

endmodule : vsc_link

/* File: vsc_core.sv */
// Voice store serial command unit: decodes frames and runs the operation sequencer.
// Assumes a 100 MHz clk with synchronous reset; the serial link uses the master's clock.
// End-of-message marks come from the storage array as a per-row level input.
`timescale 1ns/1ps
// What this block does
// RULE_01: A falling slave select starts a new frame.
// RULE_02: The master holds select low during a transfer, high between them.
// RULE_03: MOSI sampled on rising SCLK, MISO changed on falling, LSB first.
// RULE_04: A frame is 11 address bits then 5 control bits.
// RULE_05: Ending on end-of-message or overflow raises the interrupt.
// RULE_06: A pending interrupt clears when the next transfer starts.
// RULE_07: Status shifts out while address and control shift in.
// RULE_08: A set run bit starts an operation, a clear one ends it.
// RULE_09: Decoded instructions act only after select returns high.
// RULE_10: Pattern 00100 powers the device up; master waits the wake delay.
// RULE_11: Pattern 00111 plays from the supplied row.
// RULE_12: Pattern 01111 plays from the current row until marker or overflow.
// RULE_13: Pattern 00101 records from the supplied row.
// RULE_14: Pattern 01101 records from current row until overflow or stop.
// RULE_15: Pattern 10111 starts skipping at the supplied row.
// RULE_16: Pattern 11111 skips to the next marker, or overflows at the end.
// RULE_17: Pattern 011X0 halts the operation and stays powered.
// RULE_18: Pattern X10X0 halts the operation and enters standby.
// RULE_19: A 011X0 frame returns overflow and end-of-message flags on MISO.
// RULE_20: The array has 1,200 rows of 1,600 cells; address selects a row.
// RULE_21: Slave only, with interrupt output and read-only status.
// RULE_22: Control bits: skip, address ignore, power, direction, run.
// RULE_23: Status is overflow, end-of-message, then the 11-bit row pointer.
// RULE_24: With address ignore clear the same row repeats until it is set; the code advances the row for skip operations regardless.
// RULE_25: Unknown patterns are ignored; unused address bits are disregarded.
module vsc_core #(
  parameter int unsigned WAKE_CYC = vsc_pkg::WAKE_DELAY_CYC,
  parameter int unsigned ROW_CYC  = vsc_pkg::ROW_TIME_CYC
) (
  // System clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Serial link
  input  wire logic                        sclk,
  input  wire logic                        ss_n,
  input  wire logic                        mosi,
  output logic                             miso,
  output logic                             miso_oe,
  // Interrupt, active low
  output logic                             int_n,
  // Storage array side
  input  wire logic                        row_eom_mark,
  output logic [vsc_pkg::ADDR_W-1:0]       row_pointer_out,
  output logic                             powered,
  output logic                             ready,
  output logic                             listening,
  output logic                             capturing,
  output logic                             skipping
);

  // ==========================================================================
  // Link and crossings
  logic [vsc_pkg::FRAME_W-1:0]  frame_w;
  logic                         frame_tog_w;
  logic                         frame_tog_s;
  logic                         ss_n_s;
  logic [vsc_pkg::STATUS_W-1:0] status_q;
  logic [vsc_pkg::STATUS_W-1:0] status_d;

  vsc_link u_link (
    .sclk         (sclk),
    .ss_n         (ss_n),
    .mosi         (mosi),
    .miso         (miso),
    .miso_oe      (miso_oe),
    .status_in    (status_q),
    .frame_out    (frame_w),
    .frame_toggle (frame_tog_w)
  );

  vsc_sync #(.RST_VAL(1'b0)) u_sync_tog (
    .clk  (clk),
    .srst (srst),
    .din  (frame_tog_w),
    .dout (frame_tog_s)
  );

  vsc_sync #(.RST_VAL(1'b1)) u_sync_ss (
    .clk  (clk),
    .srst (srst),
    .din  (ss_n),
    .dout (ss_n_s)
  );

  // ==========================================================================
  // Edge detection on synchronised signals
  logic tog_seen_q;
  logic tog_seen_d;
  logic ss_prev_q;
  logic ss_prev_d;
  logic frame_evt;
  logic start_evt;

  always_comb begin
    tog_seen_d = frame_tog_s;
    ss_prev_d  = ss_n_s;
    frame_evt  = frame_tog_s ^ tog_seen_q;
    start_evt  = ss_prev_q & ~ss_n_s; // RULE_01
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tog_seen_q <= 1'b0;
      ss_prev_q  <= 1'b1;
    end else begin
      tog_seen_q <= tog_seen_d;
      ss_prev_q  <= ss_prev_d;
    end
  end

  // ==========================================================================
  // Decode
  logic [vsc_pkg::ADDR_W-1:0] addr_in;
  logic [vsc_pkg::CTRL_W-1:0] ctrl_in;
  vsc_pkg::vsc_cmd_t          cmd;

  always_comb begin
    addr_in = frame_w[vsc_pkg::ADDR_W-1:0]; // RULE_04
    ctrl_in = frame_w[vsc_pkg::FRAME_W-1:vsc_pkg::ADDR_W]; // RULE_22
    cmd     = frame_evt ? vsc_pkg::vsc_decode(ctrl_in) : vsc_pkg::VSC_CMD_NONE; // RULE_25
  end

  // ==========================================================================
  // Operation sequencer
  vsc_pkg::vsc_op_t           op_q;
  vsc_pkg::vsc_op_t           op_d;
  logic                       pwr_q;
  logic                       pwr_d;
  logic [31:0]                wake_q;
  logic [31:0]                wake_d;
  logic [31:0]                tick_q;
  logic [31:0]                tick_d;
  logic [vsc_pkg::ADDR_W-1:0] ptr_q;
  logic [vsc_pkg::ADDR_W-1:0] ptr_d;
  logic                       ign_q;
  logic                       ign_d;
  logic                       ovf_q;
  logic                       ovf_d;
  logic                       eom_q;
  logic                       eom_d;
  logic                       int_q;
  logic                       int_d;
  logic                       row_end;
  logic                       hit_end;
  logic                       row_mark;

  // Address selects one of the 1,200 rows; anything beyond is replaced by row zero.
  function automatic logic [vsc_pkg::ADDR_W-1:0] clip_row(input logic [10:0] a);
    return (a < vsc_pkg::ROW_COUNT) ? a : vsc_pkg::ROW_ZERO; // RULE_20
  endfunction : clip_row

  always_comb begin
    op_d     = op_q;
    pwr_d    = pwr_q;
    ptr_d    = ptr_q;
    ign_d    = ign_q;
    ovf_d    = ovf_q;
    eom_d    = eom_q;
    int_d    = int_q;
    wake_d   = (wake_q != 32'h0000_0000) ? wake_q - 32'h0000_0001 : wake_q;
    row_end  = (op_q != vsc_pkg::VSC_OP_IDLE) && (tick_q == 32'h0000_0000);
    tick_d   = row_end ? ROW_CYC[31:0] - 32'h0000_0001 :
               (op_q != vsc_pkg::VSC_OP_IDLE) ? tick_q - 32'h0000_0001 : tick_q;
    hit_end  = 1'b0;
    row_mark = row_eom_mark;

    if (start_evt) begin
      int_d = 1'b0; // RULE_06
      ovf_d = 1'b0;
      eom_d = 1'b0;
    end

    // Row advance while an operation runs.
    if (row_end) begin
      if (op_q != vsc_pkg::VSC_OP_CAPTURE && row_mark) begin
        hit_end = 1'b1;
        eom_d   = 1'b1; // RULE_16
        ptr_d   = (ptr_q == vsc_pkg::ROW_LAST) ? vsc_pkg::ROW_ZERO : ptr_q + vsc_pkg::ROW_ONE;
      end else if (ptr_q == vsc_pkg::ROW_LAST) begin
        hit_end = 1'b1;
        ovf_d   = 1'b1; // RULE_14
      end else if (ign_q || op_q == vsc_pkg::VSC_OP_SKIP) begin
        ptr_d = ptr_q + vsc_pkg::ROW_ONE;
      end else begin
        ign_d = 1'b0; // RULE_24
      end
      if (hit_end) begin
        op_d  = vsc_pkg::VSC_OP_IDLE;
        int_d = 1'b1; // RULE_05
      end
    end

    // New instruction, only after the frame closed. RULE_09
    unique case (cmd)
      vsc_pkg::VSC_CMD_WAKE: begin
        if (!pwr_q) begin
          wake_d = WAKE_CYC[31:0]; // RULE_10
        end
        pwr_d = 1'b1;
      end
      vsc_pkg::VSC_CMD_LISTEN_AT, vsc_pkg::VSC_CMD_CAPTURE_AT, vsc_pkg::VSC_CMD_SKIP_AT: begin
        if (pwr_q) begin
          ptr_d  = clip_row(addr_in); // RULE_11 RULE_13 RULE_15
          ign_d  = 1'b0;
          tick_d = ROW_CYC[31:0] - 32'h0000_0001;
          op_d   = (cmd == vsc_pkg::VSC_CMD_LISTEN_AT) ? vsc_pkg::VSC_OP_LISTEN :
                   (cmd == vsc_pkg::VSC_CMD_CAPTURE_AT) ? vsc_pkg::VSC_OP_CAPTURE :
                   vsc_pkg::VSC_OP_SKIP; // RULE_08
        end
      end
      vsc_pkg::VSC_CMD_LISTEN, vsc_pkg::VSC_CMD_CAPTURE, vsc_pkg::VSC_CMD_SKIP: begin
        if (pwr_q) begin
          ign_d = 1'b1; // RULE_12 RULE_14 RULE_16
          if (op_q == vsc_pkg::VSC_OP_IDLE) begin
            tick_d = ROW_CYC[31:0] - 32'h0000_0001;
          end
          op_d  = (cmd == vsc_pkg::VSC_CMD_LISTEN) ? vsc_pkg::VSC_OP_LISTEN :
                  (cmd == vsc_pkg::VSC_CMD_CAPTURE) ? vsc_pkg::VSC_OP_CAPTURE :
                  vsc_pkg::VSC_OP_SKIP;
        end
      end
      vsc_pkg::VSC_CMD_HALT: begin
        op_d = vsc_pkg::VSC_OP_IDLE; // RULE_17 RULE_08
      end
      vsc_pkg::VSC_CMD_SLEEP: begin
        op_d   = vsc_pkg::VSC_OP_IDLE; // RULE_18
        pwr_d  = 1'b0;
        wake_d = 32'h0000_0000;
      end
      default: begin
      end
    endcase

    // Status is frozen while a frame is on the wire so the link sees a stable word.
    status_d = ss_n_s ? {ptr_q, eom_q, ovf_q} : status_q; // RULE_23 RULE_21
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      op_q     <= vsc_pkg::VSC_OP_IDLE;
      pwr_q    <= 1'b0;
      wake_q   <= 32'h0000_0000;
      tick_q   <= 32'h0000_0000;
      ptr_q    <= 11'h000;
      ign_q    <= 1'b0;
      ovf_q    <= 1'b0;
      eom_q    <= 1'b0;
      int_q    <= 1'b0;
      status_q <= 13'h0000;
    end else begin
      op_q     <= op_d;
      pwr_q    <= pwr_d;
      wake_q   <= wake_d;
      tick_q   <= tick_d;
      ptr_q    <= ptr_d;
      ign_q    <= ign_d;
      ovf_q    <= ovf_d;
      eom_q    <= eom_d;
      int_q    <= int_d;
      status_q <= status_d;
    end
  end

  // ==========================================================================
  // Outputs
  logic [5:0] outs_q;
  logic [5:0] outs_d;

  // The interrupt bit is kept inverted so the pin leaves a flip-flop directly.
  always_comb begin
    outs_d = {pwr_q, (pwr_q && wake_q == 32'h0000_0000),
              op_q == vsc_pkg::VSC_OP_LISTEN, op_q == vsc_pkg::VSC_OP_CAPTURE,
              op_q == vsc_pkg::VSC_OP_SKIP, ~int_q};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      outs_q <= 6'h01;
    end else begin
      outs_q <= outs_d;
    end
  end

  assign powered         = outs_q[5];
  assign ready           = outs_q[4];
  assign listening       = outs_q[3];
  assign capturing       = outs_q[2];
  assign skipping        = outs_q[1];
  assign int_n           = outs_q[0];
  assign row_pointer_out = status_q[vsc_pkg::STATUS_W-1:vsc_pkg::S_PTR];

  // ==========================================================================
  // Checks
  chk_int_on_end: assert property (@(posedge clk) disable iff (srst) // RULE_05
    hit_end |=> int_q)
    else $error("interrupt not raised at operation end");

  chk_int_clear_start: assert property (@(posedge clk) disable iff (srst) // RULE_06
    start_evt && !hit_end |=> !int_q)
    else $error("interrupt not cleared at transfer start");

  chk_int_pin: assert property (@(posedge clk) disable iff (srst) // RULE_05
    int_q |=> !int_n)
    else $error("interrupt pin does not follow flag");

  chk_sleep_drop: assert property (@(posedge clk) disable iff (srst) // RULE_18
    cmd == vsc_pkg::VSC_CMD_SLEEP |=> !pwr_q && op_q == vsc_pkg::VSC_OP_IDLE)
    else $error("sleep did not halt and power down");

  chk_halt_powered: assert property (@(posedge clk) disable iff (srst) // RULE_17
    cmd == vsc_pkg::VSC_CMD_HALT |=> op_q == vsc_pkg::VSC_OP_IDLE && pwr_q == $past(pwr_q))
    else $error("halt changed power or left operation running");

  chk_wake_power: assert property (@(posedge clk) disable iff (srst) // RULE_10
    cmd == vsc_pkg::VSC_CMD_WAKE |=> pwr_q ##2 powered)
    else $error("wake did not power up");

  chk_set_row: assert property (@(posedge clk) disable iff (srst) // RULE_11
    cmd == vsc_pkg::VSC_CMD_LISTEN_AT && pwr_q && !row_end |=>
      ptr_q == clip_row($past(addr_in)) && op_q == vsc_pkg::VSC_OP_LISTEN)
    else $error("addressed listen did not load row");

  chk_no_cmd_in_frame: assert property (@(posedge clk) disable iff (srst) // RULE_09
    !ss_n_s && !frame_evt |=> $stable(pwr_q))
    else $error("power changed while a frame was open");

  chk_row_range: assert property (@(posedge clk) disable iff (srst) // RULE_20
    ptr_q < vsc_pkg::ROW_COUNT)
    else $error("row pointer out of range");

  chk_eom_stop: assert property (@(posedge clk) disable iff (srst) // RULE_16
    row_end && op_q != vsc_pkg::VSC_OP_CAPTURE && row_mark && cmd == vsc_pkg::VSC_CMD_NONE
      |=> eom_q && op_q == vsc_pkg::VSC_OP_IDLE)
    else $error("marked row did not end the operation");

  chk_capture_ovf: assert property (@(posedge clk) disable iff (srst) // RULE_14
    row_end && op_q == vsc_pkg::VSC_OP_CAPTURE && ptr_q == vsc_pkg::ROW_LAST &&
      cmd == vsc_pkg::VSC_CMD_NONE |=> ovf_q && op_q == vsc_pkg::VSC_OP_IDLE)
    else $error("capture did not overflow at the last row");

endmodule : vsc_core

/* File: vsc_master.sv */
// Behavioural serial master that stands on the far side of the command unit.
// Assumes the unit samples on the rising link clock edge and is idle at time zero.
`timescale 1ns/1ps
module vsc_master (
  // Link outputs
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  // Link input
  input  wire logic miso
);
  // ==========================================================================
  // Idle state
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // ==========================================================================
  // One 16-bit transfer at a 12 ns link period
  // The link clock only runs inside a frame, and the data line is inverted
  // after release so a stale bit can never look valid.
  task automatic xfer(input logic [vsc_pkg::ADDR_W-1:0] addr,
                      input logic [vsc_pkg::CTRL_W-1:0] ctrl,
                      output logic [vsc_pkg::STATUS_W-1:0] status);
    logic [vsc_pkg::FRAME_W-1:0] frame;
    logic [vsc_pkg::FRAME_W-1:0] got;
    frame = {ctrl, addr};
    got   = '0;
    #3;
    ss_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      mosi = frame[i];
      #6;
      got[i] = miso;
      sclk   = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #6;
    ss_n   = 1'b1;
    mosi   = ~mosi;
    status = got[vsc_pkg::STATUS_W-1:0];
  endtask : xfer
endmodule : vsc_master

/* File: vsc_core_bench.sv */
// Self-checking bench for the voice store serial command unit.
// Assumes a 100 MHz system clock and the serial master model beside it.
`timescale 1ns/1ps
module vsc_core_bench;
  // ==========================================================================
  // Signals
  logic                            clk = 1'b0;
  logic                            srst;
  logic                            row_eom_mark;
  logic                            sclk;
  logic                            ss_n;
  logic                            mosi;
  logic                            miso;
  logic                            miso_oe;
  logic                            int_n;
  logic [vsc_pkg::ADDR_W-1:0]      ptr;
  logic                            powered;
  logic                            ready;
  logic                            listening;
  logic                            capturing;
  logic                            skipping;
  logic [vsc_pkg::STATUS_W-1:0]    stat;
  int                              miscompares = 0;
  int                              checks = 0;

  always #5 clk = ~clk;

  // Short wake and row times keep the run brief.
  vsc_core #(.WAKE_CYC(20), .ROW_CYC(8)) vsc_core_inst (
    .clk(clk), .srst(srst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .int_n(int_n), .row_eom_mark(row_eom_mark),
    .row_pointer_out(ptr), .powered(powered), .ready(ready),
    .listening(listening), .capturing(capturing), .skipping(skipping));

  vsc_master vsc_master_inst (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

  // ==========================================================================
  // Helpers
  task automatic conclude();
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // Select must stay high long enough for the unit to see the gap.
  task automatic send(input logic [10:0] a, input logic [4:0] c);
    wait_clk(6);
    vsc_master_inst.xfer(a, c, stat);
  endtask : send

  task automatic set_mark(input logic v);
    @(negedge clk);
    row_eom_mark <= v;
  endtask : set_mark

  // ==========================================================================
  // Scenarios
  task automatic t_wake();
    chk_bit(int_n, 1'b1);
    chk_bit(miso_oe, 1'b0);
    send(11'h07ff, 5'h01);
    wait_clk(8);
    chk_bit(powered, 1'b0);
    send(11'h07ff, 5'h04);
    chk_bit(powered, 1'b0);
    wait_clk(8);
    chk_bit(powered, 1'b1);
    chk_bit(ready, 1'b0);
    wait_clk(30);
    chk_bit(ready, 1'b1);
  endtask : t_wake

  task automatic t_listen();
    send(11'h0005, 5'h1c);
    chk_bit(listening, 1'b0);
    wait_clk(8);
    chk_bit(listening, 1'b1);
    chk_word({2'b00, ptr}, 13'h0005);
    wait_clk(40);
    chk_word({2'b00, ptr}, 13'h0005);
    send(11'h0000, 5'h0e);
    chk_word(stat, 13'h0014);
    wait_clk(8);
    chk_bit(listening, 1'b0);
    chk_bit(powered, 1'b1);
    set_mark(1'b1);
    send(11'h0000, 5'h1e);
    wait_clk(30);
    chk_bit(listening, 1'b0);
    chk_bit(int_n, 1'b0);
    send(11'h0000, 5'h0e);
    chk_word(stat & 13'h0003, 13'h0002);
    chk_bit(int_n, 1'b1);
  endtask : t_listen

  task automatic t_capture();
    set_mark(1'b0);
    send(vsc_pkg::ROW_LAST, 5'h14);
    wait_clk(8);
    chk_bit(capturing, 1'b1);
    chk_word({2'b00, ptr}, {2'b00, vsc_pkg::ROW_LAST});
    send(11'h0000, 5'h16);
    wait_clk(30);
    chk_bit(capturing, 1'b0);
    chk_bit(int_n, 1'b0);
    send(11'h0000, 5'h0e);
    chk_word(stat & 13'h0003, 13'h0001);
  endtask : t_capture

  task automatic t_skip();
    set_mark(1'b1);
    send(11'h0000, 5'h1f);
    wait_clk(30);
    chk_bit(skipping, 1'b0);
    chk_bit(int_n, 1'b0);
    set_mark(1'b0);
    send(11'h0003, 5'h1d);
    wait_clk(8);
    chk_bit(skipping, 1'b1);
    chk_word({2'b00, ptr}, 13'h0003);
    send(11'h0000, 5'h02);
    wait_clk(8);
    chk_bit(skipping, 1'b0);
    chk_bit(powered, 1'b0);
    send(11'h0005, 5'h1c);
    wait_clk(8);
    chk_bit(listening, 1'b0);
  endtask : t_skip

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    srst         = 1'b1;
    row_eom_mark = 1'b0;
    repeat (12) @(negedge clk);
    srst <= 1'b0;
    wait_clk(4);
    t_wake();
    t_listen();
    t_capture();
    t_skip();
    conclude();
  end

  // The whole sequence needs well under 10 us; a hang is cut at 200 us.
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule : vsc_core_bench
